// [hw/uepr_desc_mem.sv]
`default_nettype none
// small descriptor store, one write port, two registered read ports
module uepr_desc_mem #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 8,
	parameter int unsigned AW    = 3
) (
	input  wire logic             clk_i,
	input  wire logic             wr_en_i,
	input  wire logic [AW-1:0]    wr_addr_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic [AW-1:0]    a_addr_i,
	output logic      [WIDTH-1:0] a_data_o,
	input  wire logic [AW-1:0]    b_addr_i,
	output logic      [WIDTH-1:0] b_data_o
);
	// ***************************************************
	// storage
	// ***************************************************
	logic [WIDTH-1:0] mem_q [DEPTH];  // contents undefined after reset

	// write plus both reads; a read in the write cycle sees old data
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
		a_data_o <= mem_q[a_addr_i];
		b_data_o <= mem_q[b_addr_i];
	end
endmodule
`default_nettype wire

// [hw/uepr_regs.sv]
// Chosen here: the Wishbone register port.
`default_nettype none
// endpoint descriptor registers behind a classic wishbone slave
module uepr_regs #(
	parameter int unsigned NUM_EP = 8  // endpoint slots, slot 0 unused in the store
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	// wishbone slave
	input  wire logic                         cyc_i,
	input  wire logic                         stb_i,
	input  wire logic                         we_i,
	input  wire logic [uepr_pkg::ADR_W-1:0]   adr_i,
	input  wire logic [3:0]                   sel_i,
	input  wire logic [uepr_pkg::DAT_W-1:0]   dat_i,
	output logic      [uepr_pkg::DAT_W-1:0]   dat_o,
	output logic                              ack_o,
	// buffer manager: endpoint 1..7 lookup
	input  wire logic [uepr_pkg::EP_W-1:0]    bm_ep_i,
	output logic      [uepr_pkg::BUF_ADDR_W-1:0] bm_y_start_addr_o,
	output logic      [uepr_pkg::CNT7_W-1:0]  bm_y_count_o,
	output logic                              bm_y_nak_o,
	output logic      [uepr_pkg::CNT7_W-1:0]  bm_buffer_size_o,
	input  wire logic                         bm_in_done_i,
	input  wire logic [uepr_pkg::EP_W-1:0]    bm_in_done_ep_i,
	// buffer manager: endpoint 0
	input  wire logic                         bm_setup_i,
	input  wire logic                         bm_in0_done_i,
	input  wire logic                         bm_out0_done_i,
	input  wire logic [uepr_pkg::CNT4_W-1:0]  bm_out0_count_i,
	output logic                              in0_serve_o,
	output logic                              in0_nak_o,
	output logic                              in0_stall_o,
	output logic      [uepr_pkg::CNT4_W-1:0]  in0_count_o,
	output logic      [uepr_pkg::FIX_ADDR_W-1:0] in0_buf_addr_o,
	output logic                              out0_serve_o,
	output logic                              out0_stall_o,
	output logic      [uepr_pkg::FIX_ADDR_W-1:0] out0_buf_addr_o,
	output logic                              in0_irq_o,
	output logic                              out0_irq_o
);
	// ***************************************************
	// bus decode
	// ***************************************************
	logic [uepr_pkg::IDX_W-1:0] idx;        // register index
	logic                       req;        // request present
	logic                       wr_take;    // write takes effect this edge
	logic                       is_desc;    // inside descriptor window
	logic [1:0]                 bank;       // descriptor bank
	logic [uepr_pkg::EP_W-1:0]  ep;         // descriptor endpoint
	logic [7:0]                 wbyte;      // written byte

	assign idx     = adr_i[uepr_pkg::ADR_W-1:2];
	assign req     = cyc_i & stb_i;
	assign wr_take = req & we_i & ack_o & sel_i[0];
	assign wbyte   = dat_i[7:0];
	// endpoint 0 in the store and bank 0 are left unmapped
	assign is_desc = (idx[15:5] == uepr_pkg::IDX_DESC_GROUP) && (idx[4:3] != 2'h0) && (idx[2:0] != 3'h0);
	assign bank    = idx[4:3];
	assign ep      = idx[2:0];

	// ***************************************************
	// descriptor store for endpoints 1..7
	// ***************************************************
	logic [2:0]       bank_we;            // per-bank write enable
	logic [7:0]       bank_wdata [3];     // per-bank write data
	logic [7:0]       bank_a     [3];     // bus-side read data
	logic [7:0]       bank_b     [3];     // manager-side read data

	// only software writes the store; the manager has no write path
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_bank
			assign bank_we[g]    = wr_take & is_desc & (bank == 2'(g + 1));
			// count and size keep seven bits, the top bit is not stored
			assign bank_wdata[g] = (g == 0) ? wbyte : {1'b0, wbyte[6:0]};
			uepr_desc_mem #(
				.WIDTH (8),
				.DEPTH (NUM_EP),
				.AW    (uepr_pkg::EP_W)
			) u_mem (
				.clk_i     (clk_i),
				.wr_en_i   (bank_we[g]),
				.wr_addr_i (ep),
				.wr_data_i (bank_wdata[g]),
				.a_addr_i  (ep),
				.a_data_o  (bank_a[g]),
				.b_addr_i  (bm_ep_i),
				.b_data_o  (bank_b[g])
			);
		end
	endgenerate

	// ***************************************************
	// endpoint 1..7 nak flags
	// ***************************************************
	logic [NUM_EP-1:0] nak_q;      // one per endpoint, slot 0 unused
	logic [NUM_EP-1:0] nak_d;
	logic              bm_nak_q;   // nak aligned with store read port
	logic              bm_nak_d;

	// software writes the flag; a completed in transfer sets it and wins
	always_comb begin
		nak_d    = nak_q;
		bm_nak_d = nak_q[bm_ep_i];
		if (bank_we[1]) begin
			nak_d[ep] = wbyte[uepr_pkg::BIT_NAK];
		end
		if (bm_in_done_i) begin
			nak_d[bm_in_done_ep_i] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			nak_q    <= {NUM_EP{uepr_pkg::EP_NAK_RST}};
			bm_nak_q <= uepr_pkg::EP_NAK_RST;
		end else begin
			nak_q    <= nak_d;
			bm_nak_q <= bm_nak_d;
		end
	end

	// manager view; base gets three zero low bits
	assign bm_y_start_addr_o = {bank_b[0], {uepr_pkg::ADDR_PAD_W{1'b0}}};
	// count passed as stored; software keeps it in range
	assign bm_y_count_o      = bank_b[1][uepr_pkg::CNT7_W-1:0];
	assign bm_y_nak_o        = bm_nak_q;
	assign bm_buffer_size_o  = bank_b[2][uepr_pkg::CNT7_W-1:0];

	// ***************************************************
	// endpoint 0 registers
	// ***************************************************
	logic       in_en_q, in_en_d;       // manager_use_enable
	logic       in_tog_q, in_tog_d;     // data_toggle_state
	logic       in_stall_q, in_stall_d;
	logic       in_irqen_q, in_irqen_d; // completion_irq_enable
	logic       in_nak_q, in_nak_d;
	logic [3:0] in_cnt_q, in_cnt_d;
	logic       out_en_q, out_en_d;
	logic       out_tog_q, out_tog_d;
	logic       out_stall_q, out_stall_d;
	logic       out_irqen_q, out_irqen_d;
	logic       out_nak_q, out_nak_d;
	logic [3:0] out_cnt_q, out_cnt_d;
	logic       in_irq_q, in_irq_d;
	logic       out_irq_q, out_irq_d;
	logic       wr_in_cfg, wr_in_cnt, wr_out_cfg, wr_out_cnt;

	assign wr_in_cfg  = wr_take && (idx == uepr_pkg::IDX_IN_EP0_CONFIG);
	assign wr_in_cnt  = wr_take && (idx == uepr_pkg::IDX_IN_EP0_BYTE_COUNT);
	assign wr_out_cfg = wr_take && (idx == uepr_pkg::IDX_OUT_EP0_CONFIG);
	assign wr_out_cnt = wr_take && (idx == uepr_pkg::IDX_OUT_EP0_BYTE_COUNT);

	// next state: setup first, then software writes, then completions on top
	always_comb begin
		in_en_d     = in_en_q;
		in_tog_d    = in_tog_q;
		in_stall_d  = in_stall_q;
		in_irqen_d  = in_irqen_q;
		in_nak_d    = in_nak_q;
		in_cnt_d    = in_cnt_q;
		out_en_d    = out_en_q;
		out_tog_d   = out_tog_q;
		out_stall_d = out_stall_q;
		out_irqen_d = out_irqen_q;
		out_nak_d   = out_nak_q;
		out_cnt_d   = out_cnt_q;
		// setup: stalls end, data stage starts on data1
		if (bm_setup_i) begin
			in_stall_d  = 1'b0;
			out_stall_d = 1'b0;
			in_tog_d    = 1'b1;
			out_tog_d   = 1'b1;
		end
		// software config writes; a stall set in the setup cycle survives
		if (wr_in_cfg) begin
			in_en_d    = wbyte[uepr_pkg::BIT_USE_ENABLE];
			in_irqen_d = wbyte[uepr_pkg::BIT_IRQ_EN];
			in_stall_d = wbyte[uepr_pkg::BIT_STALL];
		end
		if (wr_out_cfg) begin
			out_en_d    = wbyte[uepr_pkg::BIT_USE_ENABLE];
			out_irqen_d = wbyte[uepr_pkg::BIT_IRQ_EN];
			out_stall_d = wbyte[uepr_pkg::BIT_STALL];
		end
		// software count writes; the out count itself is hardware-owned
		if (wr_in_cnt) begin
			in_nak_d = wbyte[uepr_pkg::BIT_NAK];
			in_cnt_d = wbyte[uepr_pkg::CNT4_W-1:0];
		end
		if (wr_out_cnt) begin
			out_nak_d = wbyte[uepr_pkg::BIT_NAK];
		end
		// completions win over a software clear in the same cycle
		if (bm_in0_done_i) begin
			in_nak_d = 1'b1;
			in_tog_d = ~in_tog_q;
		end
		if (bm_out0_done_i) begin
			out_nak_d = 1'b1;
			out_cnt_d = bm_out0_count_i;
			out_tog_d = ~out_tog_q;
		end
		// completion interrupt only while enabled
		in_irq_d  = bm_in0_done_i & in_irqen_q;
		out_irq_d = bm_out0_done_i & out_irqen_q;
	end

	// endpoint 0 state, reset values fixed
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			in_en_q     <= 1'b0;
			in_tog_q    <= 1'b0;
			in_stall_q  <= 1'b0;
			in_irqen_q  <= 1'b0;
			in_nak_q    <= uepr_pkg::IN_EP0_NAK_RST;
			in_cnt_q    <= 4'h0;
			out_en_q    <= 1'b0;
			out_tog_q   <= 1'b0;
			out_stall_q <= 1'b0;
			out_irqen_q <= 1'b0;
			out_nak_q   <= uepr_pkg::OUT_EP0_NAK_RST;
			out_cnt_q   <= 4'h0;
			in_irq_q    <= 1'b0;
			out_irq_q   <= 1'b0;
		end else begin
			in_en_q     <= in_en_d;
			in_tog_q    <= in_tog_d;
			in_stall_q  <= in_stall_d;
			in_irqen_q  <= in_irqen_d;
			in_nak_q    <= in_nak_d;
			in_cnt_q    <= in_cnt_d;
			out_en_q    <= out_en_d;
			out_tog_q   <= out_tog_d;
			out_stall_q <= out_stall_d;
			out_irqen_q <= out_irqen_d;
			out_nak_q   <= out_nak_d;
			out_cnt_q   <= out_cnt_d;
			in_irq_q    <= in_irq_d;
			out_irq_q   <= out_irq_d;
		end
	end

	// endpoint 0 manager view
	assign in0_serve_o     = in_en_q & ~in_nak_q;
	assign in0_nak_o       = in_nak_q;
	assign in0_stall_o     = in_stall_q;
	// reserved codes clamp to eight
	assign in0_count_o     = (in_cnt_q > uepr_pkg::EP0_MAX_COUNT) ? uepr_pkg::EP0_MAX_COUNT : in_cnt_q;
	assign in0_buf_addr_o  = uepr_pkg::IN_EP0_BUF_ADDR;
	assign out0_serve_o    = out_en_q & ~out_nak_q;
	assign out0_stall_o    = out_stall_q;
	assign out0_buf_addr_o = uepr_pkg::OUT_EP0_BUF_ADDR;
	assign in0_irq_o       = in_irq_q;
	assign out0_irq_o      = out_irq_q;

	// ***************************************************
	// bus answer
	// ***************************************************
	uepr_pkg::uepr_rd_e rsel_q, rsel_d;   // answer source
	logic [7:0]         rd0_q, rd0_d;     // endpoint 0 read byte
	logic [1:0]         rbank_q, rbank_d; // store bank being read
	logic [2:0]         rep_q, rep_d;     // store endpoint being read
	logic               ack_q, ack_d;
	logic [7:0]         rbyte;            // selected answer byte

	// answer one cycle after the request; reserved bits read zero
	always_comb begin
		ack_d   = req & ~ack_q;
		rbank_d = bank;
		rep_d   = ep;
		rd0_d   = 8'h00;
		rsel_d  = uepr_pkg::UEPR_RD_NONE;
		if (is_desc) begin
			rsel_d = uepr_pkg::UEPR_RD_MEM;
		end else begin
			unique case (idx)
				uepr_pkg::IDX_IN_EP0_CONFIG: begin
					rsel_d = uepr_pkg::UEPR_RD_EP0;
					rd0_d[uepr_pkg::BIT_USE_ENABLE] = in_en_q;
					rd0_d[uepr_pkg::BIT_TOGGLE]     = in_tog_q;
					rd0_d[uepr_pkg::BIT_STALL]      = in_stall_q;
					rd0_d[uepr_pkg::BIT_IRQ_EN]     = in_irqen_q;
				end
				uepr_pkg::IDX_IN_EP0_BYTE_COUNT: begin
					rsel_d = uepr_pkg::UEPR_RD_EP0;
					rd0_d  = {in_nak_q, 3'h0, in_cnt_q};
				end
				uepr_pkg::IDX_OUT_EP0_CONFIG: begin
					rsel_d = uepr_pkg::UEPR_RD_EP0;
					rd0_d[uepr_pkg::BIT_USE_ENABLE] = out_en_q;
					rd0_d[uepr_pkg::BIT_TOGGLE]     = out_tog_q;
					rd0_d[uepr_pkg::BIT_STALL]      = out_stall_q;
					rd0_d[uepr_pkg::BIT_IRQ_EN]     = out_irqen_q;
				end
				uepr_pkg::IDX_OUT_EP0_BYTE_COUNT: begin
					rsel_d = uepr_pkg::UEPR_RD_EP0;
					rd0_d  = {out_nak_q, 3'h0, out_cnt_q};
				end
				default: begin
					rsel_d = uepr_pkg::UEPR_RD_NONE;  // unmapped reads zero
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q   <= 1'b0;
			rsel_q  <= uepr_pkg::UEPR_RD_NONE;
			rd0_q   <= 8'h00;
			rbank_q <= 2'h0;
			rep_q   <= 3'h0;
		end else begin
			ack_q   <= ack_d;
			rsel_q  <= rsel_d;
			rd0_q   <= rd0_d;
			rbank_q <= rbank_d;
			rep_q   <= rep_d;
		end
	end

	// every source here is a flop; the mux only picks among them
	always_comb begin
		rbyte = 8'h00;
		unique case (rsel_q)
			uepr_pkg::UEPR_RD_EP0: rbyte = rd0_q;
			uepr_pkg::UEPR_RD_MEM: begin
				unique case (rbank_q)
					uepr_pkg::BANK_SECOND_BASE:  rbyte = bank_a[0];
					uepr_pkg::BANK_SECOND_COUNT: rbyte = {nak_q[rep_q], bank_a[1][6:0]};
					uepr_pkg::BANK_BUFFER_SIZE:  rbyte = {1'b0, bank_a[2][6:0]};
					default:                     rbyte = 8'h00;
				endcase
			end
			default: rbyte = 8'h00;
		endcase
	end

	assign ack_o = ack_q;
	assign dat_o = {24'h000000, rbyte};
endmodule
`default_nettype wire

// [shared/uepr_pkg.sv]
// Behaviour
// - base register holds start address bits ten to three
// - hardware never rewrites the base register
// - count bit 7 set means empty, nak
// - size field seven bits, top bit reads zero
// - endpoint 0 uses four dedicated registers
// - endpoint 0 buffers fixed at fef8, fef0
// - endpoint 0 registers decode at ff80 to ff83
// - interrupt enable bit gates completion interrupt
// - software stall bit cleared by next setup
// - toggle bit read-only, shows data toggle
// - manager serves endpoint only while enabled
// - endpoint 0 count codes above eight act as eight
// - endpoint 0 in nak resets to one
`default_nettype none
package uepr_pkg;
	// ***************************************************
	// bus geometry
	// ***************************************************
	localparam int unsigned ADR_W  = 18;  // byte address width
	localparam int unsigned IDX_W  = 16;  // register index width
	localparam int unsigned DAT_W  = 32;  // bus data width
	localparam int unsigned BYTE_W = 8;   // register width
	localparam int unsigned EP_W   = 3;   // endpoint number width

	// ***************************************************
	// register indices (byte address is four times these)
	// ***************************************************
	localparam logic [15:0] IDX_IN_EP0_CONFIG      = 16'hff80;
	localparam logic [15:0] IDX_IN_EP0_BYTE_COUNT  = 16'hff81;
	localparam logic [15:0] IDX_OUT_EP0_CONFIG     = 16'hff82;
	localparam logic [15:0] IDX_OUT_EP0_BYTE_COUNT = 16'hff83;
	// descriptor window: index = group base + bank * 8 + endpoint
	localparam logic [10:0] IDX_DESC_GROUP         = 11'h7f8;
	localparam logic [1:0]  BANK_SECOND_BASE       = 2'h1;
	localparam logic [1:0]  BANK_SECOND_COUNT      = 2'h2;
	localparam logic [1:0]  BANK_BUFFER_SIZE       = 2'h3;

	// ***************************************************
	// field positions
	// ***************************************************
	localparam int unsigned BIT_NAK        = 7;  // count registers
	localparam int unsigned BIT_USE_ENABLE = 7;  // manager_use_enable
	localparam int unsigned BIT_TOGGLE     = 5;  // data_toggle_state
	localparam int unsigned BIT_STALL      = 3;
	localparam int unsigned BIT_IRQ_EN     = 2;  // completion_irq_enable
	localparam int unsigned CNT7_W         = 7;  // endpoint 1..7 count and size
	localparam int unsigned CNT4_W         = 4;  // endpoint 0 count
	localparam int unsigned ADDR_PAD_W     = 3;  // zero low bits of base
	localparam int unsigned BUF_ADDR_W     = 11;
	localparam int unsigned FIX_ADDR_W     = 16;

	// ***************************************************
	// fixed values
	// ***************************************************
	localparam logic [15:0] IN_EP0_BUF_ADDR  = 16'hfef8;
	localparam logic [15:0] OUT_EP0_BUF_ADDR = 16'hfef0;
	localparam logic [3:0]  EP0_MAX_COUNT    = 4'h8;
	localparam logic        IN_EP0_NAK_RST   = 1'b1;
	localparam logic        OUT_EP0_NAK_RST  = 1'b0;
	localparam logic        EP_NAK_RST       = 1'b1;

	// read source selected for the answer cycle
	typedef enum logic [1:0] {
		UEPR_RD_NONE,
		UEPR_RD_EP0,
		UEPR_RD_MEM
	} uepr_rd_e;
endpackage
`default_nettype wire

// [test/tb.sv]
`default_nettype none
// ****************
// descriptor register bench
// ****************
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
	logic [17:0] adr_i;
	logic [3:0]  sel_i, out0_cnt, in0_count_o;
	logic [31:0] dat_i, dat_o;
	logic [2:0]  bm_ep, done_ep;
	logic        setup, in0_done, in_done, out0_done;
	logic [10:0] bm_y_start_addr_o;
	logic [6:0]  bm_y_count_o, bm_buffer_size_o;
	logic        bm_y_nak_o, in0_serve_o, in0_nak_o, in0_stall_o, out0_serve_o, out0_stall_o;
	logic        in0_irq_o, out0_irq_o;
	logic [15:0] in0_buf_addr_o, out0_buf_addr_o;
	logic [7:0]  q;
	int          n_mismatch = 0;
	int          n_tests = 0;
	int          n_cyc = 0;

	uepr_regs uepr_regs_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o,
		.bm_ep_i(bm_ep), .bm_y_start_addr_o, .bm_y_count_o, .bm_y_nak_o, .bm_buffer_size_o,
		.bm_in_done_i(in_done), .bm_in_done_ep_i(done_ep), .bm_setup_i(setup), .bm_in0_done_i(in0_done),
		.bm_out0_done_i(out0_done), .bm_out0_count_i(out0_cnt), .in0_serve_o, .in0_nak_o, .in0_stall_o,
		.in0_count_o, .in0_buf_addr_o, .out0_serve_o, .out0_stall_o, .out0_buf_addr_o, .in0_irq_o, .out0_irq_o);
	uepr_bm_model bm (.clk_i, .ep_o(bm_ep), .done_ep_o(done_ep), .setup_o(setup), .in0_done_o(in0_done),
		.in_done_o(in_done), .out0_done_o(out0_done), .out0_cnt_o(out0_cnt));

	// 25 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// compare and count
	task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// classic single cycle, held until ack, then one idle cycle
	// always launched just after a rising edge, even when called from a falling one
	task automatic wb(input logic w, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] s);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= {idx, 2'h0};
		dat_i <= {24'h0, d};
		sel_i <= s;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o[7:0];
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rdc(input logic [15:0] idx, input logic [7:0] exp);
		wb(1'b0, idx, 8'h00, 4'hf);
		chk($sformatf("reg %h", idx), {8'h0, q}, {8'h0, exp});
	endtask
	task automatic final_report();
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// hang guard, run needs about three hundred cycles
	always @(posedge clk_i) begin
		n_cyc <= n_cyc + 1;
		if (n_cyc == 5000) begin
			n_mismatch++;
			final_report();
		end
	end
	// main sequence
	initial begin
		{rst_i, cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} = {1'b1, 57'h0};
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rdc(16'hff80, 8'h00);
		rdc(16'hff81, 8'h80);
		rdc(16'hff82, 8'h00);
		rdc(16'hff83, 8'h00);
		chk("in0 addr", in0_buf_addr_o, 16'hfef8);
		chk("out0 addr", out0_buf_addr_o, 16'hfef0);
		// read-only toggle and reserved bits ignore writes
		wb(1'b1, 16'hff80, 8'hff, 4'hf);
		rdc(16'hff80, 8'h8c);
		chk("stall", 16'(in0_stall_o), 16'h1);
		bm.pulse(0, 3'h0, 4'h0);
		@(negedge clk_i);
		chk("stall", 16'(in0_stall_o), 16'h0);
		rdc(16'hff80, 8'ha4);
		// count code above eight, then completion with irq on
		wb(1'b1, 16'hff81, 8'h7b, 4'hf);
		rdc(16'hff81, 8'h0b);
		chk("in0 count", 16'(in0_count_o), 16'h8);
		chk("serve", 16'(in0_serve_o), 16'h1);
		bm.pulse(1, 3'h0, 4'h0);
		@(negedge clk_i);
		chk("irq", 16'(in0_irq_o), 16'h1);
		rdc(16'hff81, 8'h8b);
		rdc(16'hff80, 8'h84);
		// masked irq, disabled endpoint
		wb(1'b1, 16'hff80, 8'h00, 4'hf);
		wb(1'b1, 16'hff81, 8'h08, 4'hf);
		chk("serve", 16'(in0_serve_o), 16'h0);
		bm.pulse(1, 3'h0, 4'h0);
		@(negedge clk_i);
		chk("irq", 16'(in0_irq_o), 16'h0);
		// output endpoint 0, toggle on data1 since the setup; lane 0 disabled write dropped
		wb(1'b1, 16'hff82, 8'h84, 4'he);
		rdc(16'hff82, 8'h20);
		wb(1'b1, 16'hff82, 8'h84, 4'hf);
		rdc(16'hff82, 8'ha4);
		chk("out serve", 16'(out0_serve_o), 16'h1);
		bm.pulse(3, 3'h0, 4'h6);
		@(negedge clk_i);
		chk("out irq", 16'(out0_irq_o), 16'h1);
		rdc(16'hff83, 8'h86);
		chk("out serve", 16'(out0_serve_o), 16'h0);
		// unmapped places
		wb(1'b1, 16'hff08, 8'h55, 4'hf);
		rdc(16'hff08, 8'h00);
		rdc(16'hff00, 8'h00);
		// endpoints 1 to 7, counts up to 64
		for (int n = 1; n < 8; n++) begin
			wb(1'b1, 16'hff08 + 16'(n), 8'(8'h90 + n), 4'hf);
			wb(1'b1, 16'hff10 + 16'(n), 8'(8'h39 + n), 4'hf);
			wb(1'b1, 16'hff18 + 16'(n), 8'(8'hc0 + n), 4'hf);
			rdc(16'hff18 + 16'(n), 8'(8'h40 + n));
			bm.look(3'(n));
			@(negedge clk_i);
			chk("y addr", 16'(bm_y_start_addr_o), 16'((8'h90 + n) * 8));
			chk("y count", 16'(bm_y_count_o), 16'(8'h39 + n));
			chk("y nak", 16'(bm_y_nak_o), 16'h0);
			chk("size", 16'(bm_buffer_size_o), 16'(8'h40 + n));
			bm.pulse(2, 3'(n), 4'h0);
			rdc(16'hff10 + 16'(n), 8'(8'hb9 + n));
			rdc(16'hff08 + 16'(n), 8'(8'h90 + n));
		end
		final_report();
	end
endmodule
`default_nettype wire

// [test/uepr_bm_model.sv]
`default_nettype none
// ****************
// buffer manager stand-in: lookups and completion pulses
// ****************
module uepr_bm_model (
	input  wire logic       clk_i,
	output logic      [2:0] ep_o,
	output logic      [2:0] done_ep_o,
	output logic            setup_o,
	output logic            in0_done_o,
	output logic            in_done_o,
	output logic            out0_done_o,
	output logic      [3:0] out0_cnt_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// quiet at time zero
	initial begin
		{ep_o, done_ep_o, setup_o, in0_done_o, in_done_o, out0_done_o, out0_cnt_o} = '0;
	end
	// one-cycle pulse; qualifiers flip once released so stale values show
	task automatic pulse(input int kind, input logic [2:0] ep, input logic [3:0] cnt);
		@(posedge clk_i);
		case (kind)
			0: setup_o <= 1'b1;
			1: in0_done_o <= 1'b1;
			2: in_done_o <= 1'b1;
			default: out0_done_o <= 1'b1;
		endcase
		done_ep_o <= ep;
		out0_cnt_o <= cnt;
		@(posedge clk_i);
		{setup_o, in0_done_o, in_done_o, out0_done_o} <= 4'h0;
		done_ep_o <= ~ep;
		out0_cnt_o <= ~cnt;
	endtask
	// lookup only reads, the base is never written back
	task automatic look(input logic [2:0] ep);
		@(posedge clk_i);
		ep_o <= ep;
		@(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// [test/uepr_props.sv]
`default_nettype none
// ****************
// port checks for the descriptor registers
// ****************
module uepr_props (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        we_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic [10:0] bm_y_start_addr_o,
	input wire logic        bm_setup_i,
	input wire logic        bm_in0_done_i,
	input wire logic        in0_serve_o,
	input wire logic        in0_nak_o,
	input wire logic        in0_stall_o,
	input wire logic        out0_stall_o,
	input wire logic [3:0]  in0_count_o,
	input wire logic [15:0] in0_buf_addr_o,
	input wire logic [15:0] out0_buf_addr_o,
	input wire logic        in0_irq_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// one clock domain, one reset
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a fresh request is answered in the next cycle
	property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
	a_ack_answer: assert property (p_ack_answer) else $error("request not acked");
	// ack never stretches
	property p_ack_single; ack_o |=> !ack_o; endproperty
	a_ack_single: assert property (p_ack_single) else $error("ack held two cycles");
	// registers are a byte wide, upper lanes zero
	property p_rd_upper; ack_o && !we_i |-> dat_o[31:8] == 24'h0; endproperty
	a_rd_upper: assert property (p_rd_upper) else $error("upper read lanes set");
	// endpoint 0 buffers are hardwired
	property p_buf_addr; in0_buf_addr_o == 16'hfef8 && out0_buf_addr_o == 16'hfef0; endproperty
	a_buf_addr: assert property (p_buf_addr) else $error("ep0 buffer address wrong");
	// an empty buffer is never offered
	property p_serve; in0_nak_o |-> !in0_serve_o; endproperty
	a_serve: assert property (p_serve) else $error("served while nak");
	// reserved count codes act as eight
	property p_clamp; in0_count_o <= 4'h8; endproperty
	a_clamp: assert property (p_clamp) else $error("count above eight");
	// setup clears stall unless software sets it in the same cycle
	property p_stall_clr; bm_setup_i && !(ack_o && we_i) |=> !in0_stall_o && !out0_stall_o; endproperty
	a_stall_clr: assert property (p_stall_clr) else $error("stall kept over setup");
	// a finished in transfer empties the buffer
	property p_done_nak; bm_in0_done_i |=> in0_nak_o; endproperty
	a_done_nak: assert property (p_done_nak) else $error("nak not set on done");
	// interrupt only follows a completion
	property p_irq_cause; in0_irq_o |-> $past(bm_in0_done_i); endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("irq without done");
	// nak comes out of reset set
	property p_nak_rst; $fell(rst_i) |-> in0_nak_o; endproperty
	a_nak_rst: assert property (p_nak_rst) else $error("nak clear after reset");
	// start address carries three zero low bits
	property p_base_pad; bm_y_start_addr_o[2:0] == 3'h0; endproperty
	a_base_pad: assert property (p_base_pad) else $error("start address not padded");
endmodule
bind uepr_regs uepr_props uepr_props_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .dat_o, .ack_o,
	.bm_y_start_addr_o, .bm_setup_i, .bm_in0_done_i, .in0_serve_o, .in0_nak_o, .in0_stall_o,
	.out0_stall_o, .in0_count_o, .in0_buf_addr_o, .out0_buf_addr_o, .in0_irq_o);
`default_nettype wire
